/* common/tap_consts.vh */
// constants for the boundary-scan test port: states, opcodes, register lengths, field positions
// assumes inclusion by the test port core and by the bench files
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

// controller states
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SHIFT_IR 4'hb
`define ST_EXIT1_IR 4'hc
`define ST_PAUSE_IR 4'hd
`define ST_EXIT2_IR 4'he
`define ST_UPD_IR 4'hf

// instruction register
`define IR_LEN 6
`define IR_CAPTURE_LOW 2'h1

// opcodes
`define OP_BYPASS 6'h3f
`define OP_ERROR 6'h11
`define OP_LONG_ID 6'h12
`define OP_PART_ID 6'h09
`define OP_SERIAL 6'h13
`define OP_UNLOCK 6'h14
`define OP_STATE 6'h15
`define OP_RESTART 6'h16
`define OP_CUSTOMER 6'h08
`define OP_IMG_LOAD 6'h05
`define OP_IMG_READ 6'h04

// data register lengths
`define ERR_LEN 160
`define SERIAL_LEN 128
`define STATE_LEN 36
`define WORD_LEN 32

// error report field positions
`define FIRST_BOOT_HI 147
`define FIRST_BOOT_LO 136
`define LAST_BOOT_HI 135
`define LAST_BOOT_LO 124
`define MAJOR_HI 123
`define MAJOR_LO 110
`define MINOR_HI 109
`define MINOR_LO 94
`define GSW_HI 93
`define GSW_LO 64
`define RSVD_BIT 63
`define FATAL_BIT 62
`define RECOV_BIT 61

`endif

/* core/tap_state_step.v */
// next-state logic of the sixteen-state test controller
// assumes the caller registers the result on a sampled test clock rise
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"

module tap_state_step
(
	// present state and mode select
	input wire [3:0] cur,
	input wire mode,
	// chosen next state
	output reg [3:0] nxt
);

	always @*
	begin
		case (cur)
			`ST_RESET: nxt = mode ? `ST_RESET : `ST_IDLE;
			`ST_IDLE: nxt = mode ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR: nxt = mode ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR: nxt = mode ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_SHIFT_DR: nxt = mode ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_EXIT1_DR: nxt = mode ? `ST_UPD_DR : `ST_PAUSE_DR;
			`ST_PAUSE_DR: nxt = mode ? `ST_EXIT2_DR : `ST_PAUSE_DR;
			`ST_EXIT2_DR: nxt = mode ? `ST_UPD_DR : `ST_SHIFT_DR;
			`ST_UPD_DR: nxt = mode ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR: nxt = mode ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR: nxt = mode ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_SHIFT_IR: nxt = mode ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_EXIT1_IR: nxt = mode ? `ST_UPD_IR : `ST_PAUSE_IR;
			`ST_PAUSE_IR: nxt = mode ? `ST_EXIT2_IR : `ST_PAUSE_IR;
			`ST_EXIT2_IR: nxt = mode ? `ST_UPD_IR : `ST_SHIFT_IR;
			`ST_UPD_IR: nxt = mode ? `ST_SEL_DR : `ST_IDLE;
			default: nxt = `ST_RESET;
		endcase
	end

endmodule

`default_nettype wire

/* core/tap_register_set.v */
// boundary-scan test port: controller, instruction register, data registers
// assumes tck, tms, tdi arrive from pins; clk samples them and finds tck edges
// Function
// RL1: controller is the standard sixteen-state boundary-scan machine.
// RL2: state moves only on test clock rise, chosen by sampled mode select.
// RL3: host sets mode select before each rising test clock edge.
// RL4: two seven-state paths, instruction and data, behave alike.
// RL5: data register acts only in data states, instruction only in instruction states.
// RL6: six-bit instruction register holds opcode, captures device status bits.
// RL7: host scans ten instruction bits: four debug-port then six controller bits.
// RL8: 160-bit error report register captures and shifts out error status.
// RL9: 32-bit long identity register loads extended identity code on capture.
// RL10: 32-bit part identity register loads device identity code on capture.
// RL11: 128-bit register captures the unique chip serial for readout.
// RL12: host shifts a 32-bit authenticated unlock packet into a register.
// RL13: 36-bit register captures the management controller overall state.
// RL14: 32-bit customer tag register captures a user-designated value.
// RL15: image load or readback routes scan path to slave boot interface.
// RL16: host loads images with load opcode, reads back with readback opcode.
// RL17: first boot error at 147:136, last boot error at 135:124.
// RL18: loader major code at 123:110, minor code at 109:94.
// RL19: general software error code sits at bits 93:64.
// RL20: bit 62 flags fatal boot rom error.
// RL21: bit 61 flags recoverable loader boot error.
// RL22: serial input sampled into selected register on each test clock rise.
// RL23: serial output changes on falling edge, driven only while shifting.
// RL24: reserved error bits 159:148 and 63 shift out as zero.
// RL25: unknown or unauthorised opcodes select the one-bit bypass path.
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"

module tap_register_set
#(
	parameter [31:0] LONG_ID_VALUE = 32'h0000_0001, // arbitrary value
	parameter [31:0] PART_ID_VALUE = 32'h0000_0001 // arbitrary value
)
(
	// system
	input wire clk,
	input wire rst,
	// test pins
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo_q,
	output reg tdo_oe_q,
	// device status sources
	input wire [1:0] ir_status,
	input wire [11:0] first_boot_error_code,
	input wire [11:0] last_boot_error_code,
	input wire [13:0] loader_major_code,
	input wire [15:0] loader_minor_code,
	input wire [29:0] general_software_error_code,
	input wire boot_rom_fatal_flag,
	input wire loader_recoverable_flag,
	input wire [60:0] other_error_flags,
	input wire [127:0] unique_chip_serial,
	input wire [35:0] manager_overall_state,
	input wire [31:0] customer_tag_word,
	input wire full_access,
	// unlock packet out
	output reg [31:0] debug_unlock_packet_q,
	output reg unlock_valid_q,
	// slave boot interface
	input wire boot_tdo,
	output reg boot_sel_q,
	output reg boot_shift_q,
	output reg boot_tdi_q,
	output reg boot_load_q,
	// controller state
	output reg [3:0] state_q
);

	// two-stage pin synchronisers
	reg [2:0] tck_s_q;
	reg [1:0] tms_s_q;
	reg [1:0] tdi_s_q;
	reg [5:0] opcode_q;
	reg [5:0] ir_shift_q;
	reg [159:0] dr_q;
	wire [3:0] next_state;
	wire rise;
	wire fall;
	wire [159:0] err_word;
	reg [5:0] eff_op;

	assign rise = tck_s_q[1] & ~tck_s_q[2];
	assign fall = ~tck_s_q[1] & tck_s_q[2];

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tck_s_q <= 3'h7;
			tms_s_q <= 2'h3;
			tdi_s_q <= 2'h3;
		end
		else
		begin
			tck_s_q <= {tck_s_q[1:0], tck};
			tms_s_q <= {tms_s_q[0], tms};
			tdi_s_q <= {tdi_s_q[0], tdi};
		end
	end

	tap_state_step u_step
	(
		.cur(state_q),
		.mode(tms_s_q[1]),
		.nxt(next_state)
	);

	// error report word; reserved bits tied low
	assign err_word = {12'h000,
		first_boot_error_code, // see RL17
		last_boot_error_code,
		loader_major_code, // see RL18
		loader_minor_code,
		general_software_error_code, // see RL19
		1'b0, // see RL24
		boot_rom_fatal_flag, // see RL20
		loader_recoverable_flag, // see RL21
		other_error_flags}; // see RL8

	// restricted opcodes collapse to bypass until full access is granted
	always @*
	begin
		case (opcode_q)
			`OP_ERROR, `OP_LONG_ID, `OP_PART_ID, `OP_SERIAL, `OP_UNLOCK, `OP_STATE,
			`OP_CUSTOMER: eff_op = opcode_q;
			`OP_IMG_LOAD, `OP_IMG_READ: eff_op = full_access ? opcode_q : `OP_BYPASS;
			default: eff_op = `OP_BYPASS; // see RL25
		endcase
	end

	function [159:0] capture_val;
		input [5:0] op;
		begin
			case (op)
				`OP_ERROR: capture_val = err_word;
				`OP_LONG_ID: capture_val = {128'h0, LONG_ID_VALUE}; // see RL9
				`OP_PART_ID: capture_val = {128'h0, PART_ID_VALUE}; // see RL10
				`OP_SERIAL: capture_val = {32'h0, unique_chip_serial}; // see RL11
				`OP_STATE: capture_val = {124'h0, manager_overall_state}; // see RL13
				`OP_CUSTOMER: capture_val = {128'h0, customer_tag_word}; // see RL14
				default: capture_val = 160'h0;
			endcase
		end
	endfunction

	// serial bit enters the top bit of the chosen data register, read from bit 0 after right shifts
	function [159:0] shift_in;
		input [159:0] cur;
		input [5:0] op;
		input b;
		begin
			case (op)
				`OP_ERROR: shift_in = {b, cur[159:1]};
				`OP_SERIAL: shift_in = {32'h0, b, cur[127:1]};
				`OP_STATE: shift_in = {124'h0, b, cur[35:1]};
				`OP_LONG_ID, `OP_PART_ID, `OP_UNLOCK, `OP_CUSTOMER:
					shift_in = {128'h0, b, cur[31:1]};
				default: shift_in = {159'h0, b}; // one-bit bypass
			endcase
		end
	endfunction

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= `ST_RESET;
			opcode_q <= `OP_PART_ID;
			ir_shift_q <= 6'h00;
			dr_q <= 160'h0;
			debug_unlock_packet_q <= 32'h0;
			unlock_valid_q <= 1'b0;
			boot_tdi_q <= 1'b0;
			boot_load_q <= 1'b0;
		end
		else
		begin
			unlock_valid_q <= 1'b0;
			boot_load_q <= 1'b0;
			if (rise)
			begin
				state_q <= next_state; // see RL1, RL2, RL4
				boot_tdi_q <= tdi_s_q[1];
				case (state_q)
					`ST_RESET: opcode_q <= `OP_PART_ID;
					// instruction path only; see RL5
					// status pair sits above the fixed low pair; see RL6
					`ST_CAP_IR: ir_shift_q <= {opcode_q[5:4], ir_status, `IR_CAPTURE_LOW};
					`ST_SHIFT_IR: ir_shift_q <= {tdi_s_q[1], ir_shift_q[5:1]}; // see RL22
					`ST_UPD_IR: opcode_q <= ir_shift_q;
					// data path only
					`ST_CAP_DR: dr_q <= capture_val(eff_op);
					`ST_SHIFT_DR: dr_q <= shift_in(dr_q, eff_op, tdi_s_q[1]); // see RL22
					`ST_UPD_DR:
					begin
						if (eff_op == `OP_UNLOCK)
						begin
							debug_unlock_packet_q <= dr_q[31:0]; // see RL12
							unlock_valid_q <= 1'b1;
						end
						if (eff_op == `OP_IMG_LOAD)
							boot_load_q <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// serial output and boot shift follow the falling edge; boot select follows the opcode every clock
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tdo_q <= 1'b1;
			tdo_oe_q <= 1'b0;
			boot_sel_q <= 1'b0;
			boot_shift_q <= 1'b0;
		end
		else
		begin
			boot_sel_q <= (eff_op == `OP_IMG_LOAD) || (eff_op == `OP_IMG_READ);
			if (fall)
			begin
				boot_shift_q <= (state_q == `ST_SHIFT_DR) && boot_sel_q; // see RL15
				if (state_q == `ST_SHIFT_IR)
				begin
					tdo_q <= ir_shift_q[0]; // see RL23
					tdo_oe_q <= 1'b1;
				end
				else if (state_q == `ST_SHIFT_DR)
				begin
					tdo_q <= boot_sel_q ? boot_tdo : dr_q[0]; // see RL15
					tdo_oe_q <= 1'b1;
				end
				else
				begin
					tdo_q <= 1'b1;
					tdo_oe_q <= 1'b0; // see RL23
				end
			end
		end
	end

endmodule

`default_nettype wire

/* tb/tap_checks_properties.sv */
// assertions on the test port pins and controller state
// assumes binding into tap_register_set, clk sampling the test clock
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"
module tap_checks
(
	// system
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic tck,
	input wire logic tdo_q,
	input wire logic tdo_oe_q,
	// status
	input wire logic unlock_valid_q,
	input wire logic boot_sel_q,
	input wire logic boot_shift_q,
	input wire logic [3:0] state_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// exit1 included: the enable drops on the fall after leaving shift
	wire shifting = state_q == `ST_SHIFT_DR || state_q == `ST_SHIFT_IR
		|| state_q == `ST_EXIT1_DR || state_q == `ST_EXIT1_IR;

	a_oe_shift_only: assert property (tdo_oe_q |-> shifting)
		else $error("serial output enabled outside a shift");
	a_idle_tdo_high: assert property (!tdo_oe_q && !$past(tdo_oe_q) |-> tdo_q)
		else $error("serial output not high while idle");
	a_state_on_rise: assert property (state_q != $past(state_q) |-> $past(tck, 2))
		else $error("state moved without a test clock rise");
	a_tdo_on_fall: assert property (tdo_q != $past(tdo_q) |-> !$past(tck, 2))
		else $error("serial output moved without a test clock fall");
	a_capture_step: assert property ($past(state_q) == `ST_CAP_DR
		&& state_q != `ST_CAP_DR |-> state_q == `ST_SHIFT_DR || state_q == `ST_EXIT1_DR)
		else $error("bad step out of capture");
	a_update_step: assert property (($past(state_q) == `ST_UPD_DR
		|| $past(state_q) == `ST_UPD_IR) && state_q != $past(state_q)
		|-> state_q == `ST_SEL_DR || state_q == `ST_IDLE)
		else $error("bad step out of update");
	a_reset_step: assert property ($past(state_q) == `ST_RESET
		|-> state_q == `ST_RESET || state_q == `ST_IDLE)
		else $error("bad step out of test logic reset");
	// the strobe rises on the same clock that leaves update
	a_unlock_pulse: assert property (unlock_valid_q
		|-> $past(state_q) == `ST_UPD_DR ##1 !unlock_valid_q)
		else $error("unlock strobe outside update");
	a_boot_shift: assert property (boot_shift_q |-> boot_sel_q)
		else $error("boot shift without boot select");
endmodule
bind tap_register_set tap_checks u_tap_checks (.clk, .rst, .tck, .tdo_q, .tdo_oe_q,
	.unlock_valid_q, .boot_sel_q, .boot_shift_q, .state_q);
`default_nettype wire

/* tb/jtag_host.sv */
// external test host: makes the test clock only within pulse calls, scans lsb first
// assumes the caller is in run-test-idle when a shift starts
`timescale 1ns/1ps
`default_nettype none
module jtag_host
(
	// system
	input wire logic clk,
	// pins
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	logic oe_mid;
	logic oe_seen;
	logic slow = 1'b0;
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// mode and data set half a period ahead of the rise
	task pulse(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (6) @(posedge clk);
		// alternate 120 and 130 ns periods to average a 125 ns test clock
		if (slow)
			@(posedge clk);
		slow = ~slow;
		o = tdo;
		oe_mid = tdo_oe;
		tck <= 1'b1;
		repeat (6) @(posedge clk);
		tck <= 1'b0;
	endtask
	task shift(input logic ir, input int n, input logic [199:0] din, output logic [199:0] dout);
		logic o;
		dout = '0;
		pulse(1'b1, 1'b1, o);
		if (ir)
			pulse(1'b1, 1'b1, o);
		pulse(1'b0, 1'b1, o);
		pulse(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++)
		begin
			pulse(i == n - 1, din[i], o);
			dout[i] = o;
		end
		oe_seen = oe_mid;
		pulse(1'b1, 1'b1, o);
		pulse(1'b0, 1'b1, o);
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// top bench: scans every register through the host model and checks it
// assumes jtag_host and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.vh"
module tb_top;
	localparam [31:0] LONG_ID = 32'h5a5a_1234; // arbitrary value
	localparam [31:0] PART_ID = 32'h0f0f_4321; // arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic full_access = 1'b0;
	logic boot_tdo = 1'b0;
	logic o;
	logic [1:0] ir_status = 2'h2;
	logic [11:0] first_boot_error_code = 12'ha51;
	logic [11:0] last_boot_error_code = 12'h3c7;
	logic [13:0] loader_major_code = 14'h2b9d;
	logic [15:0] loader_minor_code = 16'hc0de;
	logic [29:0] general_software_error_code = 30'h1234_5678;
	logic boot_rom_fatal_flag = 1'b1;
	logic loader_recoverable_flag = 1'b0;
	logic [60:0] other_error_flags = 61'h0f0f_0000_aaaa_5555;
	logic [127:0] unique_chip_serial = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	logic [35:0] manager_overall_state = 36'h9_8765_4321;
	logic [31:0] customer_tag_word = 32'hbeef_cafe;
	wire tck, tms, tdi, tdo_q, tdo_oe_q, unlock_valid_q;
	wire boot_sel_q, boot_shift_q, boot_tdi_q, boot_load_q;
	wire [31:0] debug_unlock_packet_q;
	wire [3:0] state_q;
	logic [5:0] ops [10] = '{`OP_ERROR, `OP_LONG_ID, `OP_PART_ID, `OP_SERIAL, `OP_STATE,
		`OP_CUSTOMER, `OP_RESTART, 6'h2a, `OP_IMG_LOAD, `OP_BYPASS};
	int lens [10] = '{`ERR_LEN, 32, 32, `SERIAL_LEN, `STATE_LEN, 32, 1, 1, 1, 1};
	logic [159:0] caps [10];
	logic [199:0] v;
	logic [5:0] prev;
	int failures = 0;
	int check_count = 0;
	int unlock_pulses = 0;
	int load_pulses = 0;
	logic boot_shift_seen = 1'b0;

	always #5 clk = ~clk;
	always @(posedge clk) boot_tdo <= ~boot_tdi_q;
	// one-clock strobes are counted here so no scan can miss them
	always @(posedge clk)
	begin
		if (unlock_valid_q)
			unlock_pulses <= unlock_pulses + 1;
		if (boot_load_q)
			load_pulses <= load_pulses + 1;
		if (boot_shift_q)
			boot_shift_seen <= 1'b1;
	end

	jtag_host u_jtag_host (.clk, .tck, .tms, .tdi, .tdo(tdo_q), .tdo_oe(tdo_oe_q));
	tap_register_set #(.LONG_ID_VALUE(LONG_ID), .PART_ID_VALUE(PART_ID)) u_tap_register_set
		(.clk, .rst, .tck, .tms, .tdi, .tdo_q, .tdo_oe_q, .ir_status, .first_boot_error_code,
		.last_boot_error_code, .loader_major_code, .loader_minor_code,
		.general_software_error_code, .boot_rom_fatal_flag, .loader_recoverable_flag,
		.other_error_flags, .unique_chip_serial, .manager_overall_state, .customer_tag_word,
		.full_access, .debug_unlock_packet_q, .unlock_valid_q, .boot_tdo, .boot_sel_q,
		.boot_shift_q, .boot_tdi_q, .boot_load_q, .state_q);

	task check(input string name, input logic [199:0] seen, input logic [199:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task ir(input logic [5:0] op);
		// ten-bit chip scan: the first four bits stand for the debug-port register
		u_jtag_host.shift(1'b1, 10, {190'h0, op, 4'hf}, v);
		check("ir capture", v, {190'h0, 4'hf, prev[5:4], ir_status, 2'b01});
		prev = op;
	endtask
	task final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#300_000;
		failures++;
		final_report;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		check("reset state", state_q, `ST_RESET);
		check("idle tdo", {tdo_oe_q, tdo_q}, 2'b01);
		prev = `OP_PART_ID;
		caps = '{{12'h0, first_boot_error_code, last_boot_error_code, loader_major_code,
			loader_minor_code, general_software_error_code, 1'b0, boot_rom_fatal_flag,
			loader_recoverable_flag, other_error_flags}, LONG_ID, PART_ID, unique_chip_serial,
			manager_overall_state, customer_tag_word, 0, 0, 0, 0};
		u_jtag_host.pulse(1'b0, 1'b1, o);
		check("idle state", state_q, `ST_IDLE);
		u_jtag_host.shift(1'b0, 40, 200'hc3, v);
		check("default id", v, PART_ID | (200'hc3 << 32));
		check("oe in shift", u_jtag_host.oe_seen, 1'b1);
		check("oe after", tdo_oe_q, 1'b0);
		// eight extra bits prove each register length exactly
		for (int k = 0; k < 10; k++)
		begin
			ir(ops[k]);
			u_jtag_host.shift(1'b0, lens[k] + 8, 200'hc3, v);
			check("scan", v, caps[k] | (200'hc3 << lens[k]));
			$display("scan test %0d done", k);
		end
		check("boot quiet", {boot_shift_seen, load_pulses}, 0);
		ir(`OP_UNLOCK);
		u_jtag_host.shift(1'b0, 32, 200'h7e57_a11d, v);
		check("unlock", debug_unlock_packet_q, 32'h7e57_a11d);
		check("unlock pulses", unlock_pulses, 1);
		full_access <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			ir(k ? `OP_IMG_READ : `OP_IMG_LOAD);
			check("boot select", boot_sel_q, 1'b1);
			u_jtag_host.shift(1'b0, 8, 200'hc3, v);
			// boot stand-in returns each bit inverted one test clock late
			check("boot path", v[7:0], 8'h78);
		end
		check("boot shift", boot_shift_seen, 1'b1);
		check("load pulses", load_pulses, 1);
		ir(`OP_BYPASS);
		check("boot release", boot_sel_q, 1'b0);
		$display("image test done");
		repeat (5) u_jtag_host.pulse(1'b1, 1'b1, o);
		check("five ones", state_q, `ST_RESET);
		final_report;
	end
endmodule
`default_nettype wire
